// File: hw/plcc_pkg.sv
package plcc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] LOOP_CONTROL_OFS = 8'h1c;
  localparam logic [7:0] BANDWIDTH_CONTROL_OFS = 8'h1d;
  localparam logic [7:0] LOOP_PROGRAMMING_OFS = 8'h1e;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int LC_IRQ_EN_BIT = 7;
  localparam int LC_FLAG_BIT = 6;
  localparam int LC_POWER_BIT = 5;
  localparam int LC_SOURCE_BIT = 4;
  localparam int BW_AUTO_BIT = 7;
  localparam int BW_SETTLED_BIT = 6;
  localparam int BW_PHASE_BIT = 5;
  localparam int BW_XLOSS_BIT = 4;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [3:0] LC_RESERVED_VAL = 4'hf;
  localparam logic [3:0] RATIO_RST = 4'h6;
  localparam logic [3:0] RANGE_RST = 4'h6;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;

  // ****************************************
  // Clock selector timing
  // ****************************************
  localparam int SWITCH_EDGES = 3;
  localparam logic [1:0] SWITCH_LAST = 2'h2;

endpackage : plcc_pkg

// File: hw/plcc_edge_sync.sv
`timescale 1ns/1ns
`default_nettype none
module plcc_edge_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous level in
  input wire logic level_in,
  // Synchronised level out
  output logic level_out
);

  logic meta_r;
  logic sync_r;

  // Two stages; the first is read only by the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= level_in;
      sync_r <= meta_r;
    end
  end

  assign level_out = sync_r;

endmodule // plcc_edge_sync
`default_nettype wire

// File: hw/plcc_regs.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
`default_nettype none
// Function
// - Interrupt enable locked to zero in manual
// - Settled change sets flag; flag and enable interrupt
// - Control register read clears flag; reset clears
// - Manual mode reads flag zero, masks interrupt
// - Power resets on; held while VCO selected
// - Source select refused while power off
// - Output held three edges of each clock
// - Select picks VCO or crystal, halved
// - Control low nibble reads all ones
// - Automatic mode bit, read/write, reset clear
// - Settled indication, auto only, reset clear
// - Phase bit: status in auto, control manual
// - Manual phase value kept during auto
// - Crystal loss test only with VCO source
// - Ratio upper nibble, reset six
// - Programming register read-only while powered
// - Range lower nibble, protected, reset six
// - Zero range kills loop and source select
// - Loop interrupt only in automatic mode
// - Interrupt line from flag and enable
module plcc_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  // Analog loop status
  input wire logic loop_settled_in,
  input wire logic tracking_in,
  input wire logic crystal_lost_in,
  input wire logic stop_req,
  // Source clocks, sampled into this domain here through two stages
  input wire logic crystal_clk,
  input wire logic vco_clk,
  // Outputs
  output logic base_clock_out,
  output logic loop_enable,
  output logic wide_band_phase_n,
  output logic [3:0] feedback_ratio,
  output logic [3:0] vco_range_factor,
  output logic crystal_test_start,
  output logic loop_irq_line
);

  // ****************************************
  // Synchronisers
  // ****************************************
  logic settled_s;
  logic lost_s;
  logic track_s;
  logic xs_meta_r, xs_r, xs_d_r;
  logic vs_meta_r, vs_r, vs_d_r;

  plcc_edge_sync u_settled (.clk(clk), .rst_n(rst_n), .level_in(loop_settled_in),
    .level_out(settled_s));
  plcc_edge_sync u_lost (.clk(clk), .rst_n(rst_n), .level_in(crystal_lost_in),
    .level_out(lost_s));
  plcc_edge_sync u_track (.clk(clk), .rst_n(rst_n), .level_in(tracking_in),
    .level_out(track_s));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xs_meta_r <= 1'b0;
      xs_r <= 1'b0;
      xs_d_r <= 1'b0;
      vs_meta_r <= 1'b0;
      vs_r <= 1'b0;
      vs_d_r <= 1'b0;
    end else begin
      xs_meta_r <= crystal_clk;
      xs_r <= xs_meta_r;
      xs_d_r <= xs_r;
      vs_meta_r <= vco_clk;
      vs_r <= vs_meta_r;
      vs_d_r <= vs_r;
    end
  end

  // ****************************************
  // Register state
  // ****************************************
  logic irq_en_r, flag_r, power_r, source_r;
  logic auto_r, settled_r, phase_man_r, xloss_r;
  logic [3:0] ratio_r, range_r;
  logic wr_ctl, wr_bw, wr_pg, rd_ctl;
  logic range_zero;

  assign wr_ctl = wr_en && (addr == plcc_pkg::LOOP_CONTROL_OFS);
  assign wr_bw = wr_en && (addr == plcc_pkg::BANDWIDTH_CONTROL_OFS);
  assign wr_pg = wr_en && (addr == plcc_pkg::LOOP_PROGRAMMING_OFS);
  assign rd_ctl = rd_en && (addr == plcc_pkg::LOOP_CONTROL_OFS);
  assign range_zero = (range_r == plcc_pkg::NIBBLE_ZERO);

  // Automatic mode bit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      auto_r <= 1'b0;
    end else if (wr_bw) begin
      auto_r <= wdata[plcc_pkg::BW_AUTO_BIT];
    end
  end

  // Interrupt enable; writes dropped in manual mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_en_r <= 1'b0;
    end else if (!auto_r) begin
      irq_en_r <= 1'b0;
    end else if (wr_ctl) begin
      irq_en_r <= wdata[plcc_pkg::LC_IRQ_EN_BIT];
    end
  end

  // Settled tracking, gated by mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      settled_r <= 1'b0;
    end else begin
      settled_r <= settled_s && auto_r;
    end
  end

  // Flag: a change in the read cycle still sets it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if ((settled_s && auto_r) != settled_r) begin
      flag_r <= 1'b1;
    end else if (rd_ctl) begin
      flag_r <= 1'b0;
    end
  end

  // Power switch; cannot drop while VCO selected
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      power_r <= 1'b1;
    end else if (wr_ctl && !source_r) begin
      power_r <= wdata[plcc_pkg::LC_POWER_BIT];
    end
  end

  // Source select; needs power and nonzero range
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      source_r <= 1'b0;
    end else if (stop_req || range_zero || !power_r) begin
      source_r <= 1'b0;
    end else if (wr_ctl) begin
      source_r <= wdata[plcc_pkg::LC_SOURCE_BIT];
    end
  end

  // Manual phase store survives automatic periods
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_man_r <= 1'b0;
    end else if (wr_bw && !auto_r) begin
      phase_man_r <= wdata[plcc_pkg::BW_PHASE_BIT];
    end
  end

  // Crystal loss test latch; a loss seen beats the arming write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xloss_r <= 1'b0;
    end else if (!source_r) begin
      xloss_r <= 1'b0;
    end else if (lost_s) begin
      xloss_r <= 1'b1;
    end else if (wr_bw && wdata[plcc_pkg::BW_XLOSS_BIT]) begin
      xloss_r <= 1'b0;
    end
  end

  // Programming fields, frozen while powered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ratio_r <= plcc_pkg::RATIO_RST;
      range_r <= plcc_pkg::RANGE_RST;
    end else if (wr_pg && !power_r) begin
      ratio_r <= wdata[7:4];
      range_r <= wdata[3:0];
    end
  end

  // Test start pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      crystal_test_start <= 1'b0;
    end else begin
      crystal_test_start <= wr_bw && wdata[plcc_pkg::BW_XLOSS_BIT] && source_r;
    end
  end

  // ****************************************
  // Clock selector
  // ****************************************
  // Output freezes until three edges seen on both clocks
  logic sel_r, pending_r, out_r;
  logic [1:0] xcnt_r, vcnt_r;
  logic x_rise, v_rise, new_rise;

  assign x_rise = xs_r && !xs_d_r;
  assign v_rise = vs_r && !vs_d_r;
  assign new_rise = sel_r ? v_rise : x_rise;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_r <= 1'b0;
      pending_r <= 1'b0;
      xcnt_r <= 2'h0;
      vcnt_r <= 2'h0;
    end else if (source_r != sel_r && !pending_r) begin
      pending_r <= 1'b1;
      xcnt_r <= 2'h0;
      vcnt_r <= 2'h0;
    end else if (pending_r) begin
      if (x_rise && xcnt_r != plcc_pkg::SWITCH_LAST + 2'h1) begin
        xcnt_r <= xcnt_r + 2'h1;
      end
      if (v_rise && vcnt_r != plcc_pkg::SWITCH_LAST + 2'h1) begin
        vcnt_r <= vcnt_r + 2'h1;
      end
      if (xcnt_r == plcc_pkg::SWITCH_LAST + 2'h1 && vcnt_r == plcc_pkg::SWITCH_LAST + 2'h1) begin
        sel_r <= source_r;
        pending_r <= 1'b0;
      end
    end
  end

  // Divide selected clock by two on its rising edges
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_r <= 1'b0;
    end else if (!pending_r && new_rise) begin
      out_r <= !out_r;
    end
  end

  // ****************************************
  // Read path and outputs
  // ****************************************
  logic [7:0] rd_nxt;

  always_comb begin
    rd_nxt = 8'h00;
    case (addr)
      plcc_pkg::LOOP_CONTROL_OFS: begin
        rd_nxt = {irq_en_r && auto_r, flag_r && auto_r, power_r, source_r,
                  plcc_pkg::LC_RESERVED_VAL};
      end
      plcc_pkg::BANDWIDTH_CONTROL_OFS: begin
        // Test bits read zero; writes to them are not kept
        rd_nxt = {auto_r, settled_r, wide_band_phase_n, xloss_r && source_r, 4'h0};
      end
      plcc_pkg::LOOP_PROGRAMMING_OFS: begin
        rd_nxt = {ratio_r, range_r};
      end
      default: begin
        rd_nxt = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      rdata <= rd_nxt;
    end else begin
      rdata <= 8'h00;
    end
  end

  assign wide_band_phase_n = auto_r ? track_s : phase_man_r;
  assign base_clock_out = out_r;
  assign loop_enable = power_r && !range_zero;
  // Zero ratio behaves as one in the divider
  assign feedback_ratio = (ratio_r == plcc_pkg::NIBBLE_ZERO) ? 4'h1 : ratio_r;
  assign vco_range_factor = range_r;
  assign loop_irq_line = flag_r && irq_en_r && auto_r;

  // ****************************************
  // Assertions
  // ****************************************
  irq_manual_a: assert property (@(posedge clk) disable iff (!rst_n)
    !auto_r |-> !loop_irq_line)
    else $error("irq in manual mode");
  enable_manual_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(!auto_r) |-> !irq_en_r)
    else $error("enable set in manual");
  flag_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_ctl && ((settled_s && auto_r) == settled_r) |=> !flag_r)
    else $error("flag not cleared by read");
  flag_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    ((settled_s && auto_r) != settled_r) |=> flag_r)
    else $error("flag lost");
  power_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    source_r |=> power_r)
    else $error("power dropped with vco");
  source_guard_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(source_r) |-> $past(power_r) && !$past(range_zero))
    else $error("bad select");
  prog_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(power_r) |-> $stable(range_r) && $stable(ratio_r))
    else $error("prog changed");
  ctl_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rd_ctl) |-> rdata[3:0] == plcc_pkg::LC_RESERVED_VAL)
    else $error("reserved");
  hold_out_a: assert property (@(posedge clk) disable iff (!rst_n)
    pending_r |=> $stable(out_r))
    else $error("output moved in switch");
  manual_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rd_ctl) && !$past(auto_r) |-> rdata[7:6] == 2'h0)
    else $error("flag or enable seen in manual");
  xloss_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    !source_r |=> !xloss_r)
    else $error("loss kept without vco");
  xloss_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    source_r && lost_s |=> xloss_r)
    else $error("loss not latched");
  settled_manual_a: assert property (@(posedge clk) disable iff (!rst_n)
    !auto_r |=> !settled_r)
    else $error("settled set in manual");
  phase_store_a: assert property (@(posedge clk) disable iff (!rst_n)
    auto_r |=> $stable(phase_man_r))
    else $error("phase store changed in auto");
  range_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    range_zero |=> !source_r)
    else $error("vco kept with zero range");
  stop_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    stop_req |=> !source_r)
    else $error("stop left vco selected");

endmodule // plcc_regs
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // ****************************************
  // Signals
  // ****************************************
  logic clk, rst_n, wr_en, rd_en, rd_q, stop_req;
  logic [7:0] addr, wdata, rdata, v;
  logic settled, track, xlost;
  logic xclk = 1'b0;
  logic vclk = 1'b0;
  logic base_clk, loop_en, phase_n, test_start, irq;
  logic [3:0] ratio, range;
  logic [7:0] exp_v[$];
  string exp_n[$];
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  int starts = 0;
  localparam logic [7:0] CTL = plcc_pkg::LOOP_CONTROL_OFS;
  localparam logic [7:0] BW = plcc_pkg::BANDWIDTH_CONTROL_OFS;
  localparam logic [7:0] PG = plcc_pkg::LOOP_PROGRAMMING_OFS;

  plcc_regs uut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .loop_settled_in(settled), .tracking_in(track),
    .crystal_lost_in(xlost), .stop_req(stop_req), .crystal_clk(xclk), .vco_clk(vclk),
    .base_clock_out(base_clk), .loop_enable(loop_en), .wide_band_phase_n(phase_n),
    .feedback_ratio(ratio), .vco_range_factor(range), .crystal_test_start(test_start),
    .loop_irq_line(irq)
  );

  // ****************************************
  // Clocks
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Slow sources kept well under a quarter of the bus clock
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) vclk <= ~vclk;
    if (cyc % 6 == 5) xclk <= ~xclk;
  end

  // ****************************************
  // Checking
  // ****************************************
  task automatic chk(string n, logic [7:0] seen, logic [7:0] want);
    checks++;
    if (seen !== want) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, want, seen);
    end
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    rd_q <= rd_en;
    if (rd_q === 1'b1) chk(exp_n.pop_front(), rdata, exp_v.pop_front());
  end

  // Crystal test pulses, counted at the edge after they rise
  always @(posedge clk) begin
    if (test_start === 1'b1) starts <= starts + 1;
  end

  task automatic stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************
  // Bus and helpers
  // ****************************************
  task automatic cycles(int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] e, string n);
    exp_v.push_back(e);
    exp_n.push_back(n);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
  endtask

  // Spacing of output toggles; sampled 1 ns late so the edge has landed
  task automatic gap(logic [7:0] want);
    int n = 0;
    logic b;
    cycles(40);
    #1 b = base_clk;
    while (base_clk === b && n < 50) begin @(posedge clk); #1; n++; end
    n = 0;
    b = base_clk;
    while (base_clk === b && n < 50) begin @(posedge clk); #1; n++; end
    chk("clock gap", 8'(n), want);
  endtask

  initial begin
    cycles(5000);
    fails++;
    stop_test;
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {wr_en, rd_en, stop_req, settled, track, xlost} = '0;
    addr = 8'h00;
    wdata = 8'h00;
    rst_n = 1'b0;
    void'($urandom(32'h5c00));
    cycles(4);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk("loop enable", 8'(loop_en), 8'h01);
    chk("ratio", 8'(ratio), 8'h06);
    chk("range", 8'(range), 8'h06);
    rd(CTL, 8'h2f, "ctl reset");
    rd(BW, 8'h00, "bw reset");
    rd(PG, 8'h66, "prog reset");
    $display("reset test done");
    v = 8'($urandom()) | 8'h11;
    wr(PG, v);
    rd(PG, 8'h66, "prog locked");
    wr(CTL, 8'h00);
    wr(CTL, 8'h10);
    rd(CTL, 8'h0f, "source refused");
    wr(PG, v);
    rd(PG, v, "prog write");
    wr(PG, 8'h00);
    chk("ratio zero", 8'(ratio), 8'h01);
    wr(CTL, 8'h30);
    rd(CTL, 8'h2f, "range zero");
    chk("loop off", 8'(loop_en), 8'h00);
    wr(CTL, 8'h00);
    wr(PG, 8'h66);
    wr(BW, 8'h00);
    wr(CTL, 8'h20);
    wr(CTL, 8'h30);
    rd(CTL, 8'h3f, "source set");
    gap(8'h08);
    wr(CTL, 8'h10);
    rd(CTL, 8'h3f, "power held");
    wr(PG, 8'h11);
    rd(PG, 8'h66, "prog held");
    stop_req <= 1'b1;
    @(posedge clk);
    stop_req <= 1'b0;
    @(posedge clk);
    rd(CTL, 8'h2f, "stop clears");
    gap(8'h0c);
    $display("source test done");
    wr(CTL, 8'ha0);
    rd(CTL, 8'h2f, "irq en manual");
    wr(BW, 8'h80);
    wr(CTL, 8'ha0);
    settled <= 1'b1;
    cycles(6);
    chk("irq set", 8'(irq), 8'h01);
    rd(BW, 8'hc0, "settled");
    rd(CTL, 8'hef, "flag set");
    rd(CTL, 8'haf, "flag clear");
    chk("irq clear", 8'(irq), 8'h00);
    settled <= 1'b0;
    cycles(6);
    wr(BW, 8'h00);
    chk("irq manual", 8'(irq), 8'h00);
    rd(CTL, 8'h2f, "flag masked");
    $display("interrupt test done");
    wr(BW, 8'h20);
    chk("phase manual", 8'(phase_n), 8'h01);
    wr(BW, 8'ha0);
    track <= 1'b1;
    cycles(4);
    chk("phase track", 8'(phase_n), 8'h01);
    track <= 1'b0;
    cycles(4);
    chk("phase wide", 8'(phase_n), 8'h00);
    rd(BW, 8'h80, "auto phase");
    wr(BW, 8'h10);
    chk("phase restored", 8'(phase_n), 8'h01);
    rd(BW, 8'h20, "xloss no source");
    wr(CTL, 8'h30);
    xlost <= 1'b1;
    wr(BW, 8'h10);
    cycles(24);
    rd(BW, 8'h10, "xloss lost");
    chk("test start", 8'(starts), 8'h01);
    $display("status test done");
    stop_test;
  end
endmodule // testbench
`default_nettype wire
